// ==== rpm_pkg.sv ====
// shared constants and carrier types for the reader power mode controller
package rpm_pkg;
  // register port
  localparam logic [7:0] ADDR_CHIP_STATE   = 8'h00;
  localparam logic [7:0] ADDR_REG_SETTING  = 8'h0b;
  localparam logic [7:0] CHIP_STATE_RESET  = 8'h00;
  localparam logic [7:0] REG_SETTING_RESET = 8'h87;
  localparam logic [7:0] READ_UNMAPPED     = 8'h00;

  // chip state control fields
  localparam int BIT_STANDBY    = 7;
  localparam int BIT_TX_RX      = 5;
  localparam int BIT_HALF_POWER = 4;
  localparam int BIT_RX_ONLY    = 1;
  localparam int BIT_SUPPLY_5V  = 0;

  // timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int CONFIRM_TIME_NS  = 100000;
  localparam int STANDBY_REC_NS   = 100000;
  localparam int MODE1_REC_NS     = 25000;
  localparam int CONFIRM_CYC      = CONFIRM_TIME_NS / CLK_PERIOD_NS;
  localparam int STANDBY_REC_CYC  = STANDBY_REC_NS / CLK_PERIOD_NS;
  localparam int MODE1_REC_CYC    = MODE1_REC_NS / CLK_PERIOD_NS;
  localparam int TIMER_W          = 14;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_SLEEP,
    ST_STARTUP,
    ST_CONFIRM,
    ST_ACTIVE
  } pwr_state_t;

  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic hf_clk;
    logic aux_clk;
    logic mcu_supply;
    logic regulators;
    logic half_power;
    logic supply_5v;
  } pwr_out_t;

  localparam pwr_out_t PWR_OUT_OFF = '0;
endpackage

// ==== power_wait_timer.sv ====
// down counter that flags when a loaded wait has run out
`timescale 1ns/10ps
module power_wait_timer
  import rpm_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               load_i,
  input  wire logic [TIMER_W-1:0] load_val_i,
  output logic                    done_o
);
  logic [TIMER_W-1:0] cnt_ff;
  logic [TIMER_W-1:0] nxt_cnt;
  logic               done_ff;

  always_comb begin
    if (load_i) begin
      nxt_cnt = load_val_i;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff  <= '0;
      done_ff <= 1'b1;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= (nxt_cnt == '0);
    end
  end

  assign done_o = done_ff;
endmodule

// ==== reader_power_mode_control.sv ====
// power state sequencing and chip state decoding for the reader front end
// What the document asks of this block and its host
// [R1] both enables low: everything fully off; after an aux wake, start-up and the confirm window still run to the end
// [R2] aux wake only: supply rail, 60 kHz clock; entered only when main enable falls, an aux wake from off ends fully off
// [R3] aux wake rising edge starts regulators, oscillator
// [R4] settled and stable: clock switches to 13.56 MHz
// [R5] no main enable within 100 us: power down
// [R6] main enable during window keeps device active
// [R7] host separates enable transitions by 5 ms; host_model spaces them only GAP+1 = 5 clock cycles apart
// [R8] host never raises both enables together
// [R9] host ties aux wake fixed if unused
// [R10] main enable high: modes from register 0x00
// [R11] bit 7: standby, clock on, 100 us recovery
// [R12] bits 5,1 clear: RF off, 25 us recovery
// [R13] bit 1 only: receiver on, transmitter off
// [R14] bit 5: transmitter and receiver both on
// [R15] bit 4 half power, bit 0 5 V
`timescale 1ns/10ps
module reader_power_mode_control
  import rpm_pkg::*;
#(
  parameter logic [TIMER_W-1:0] CONFIRM_CYCLES     = TIMER_W'(CONFIRM_CYC),
  parameter logic [TIMER_W-1:0] STANDBY_REC_CYCLES = TIMER_W'(STANDBY_REC_CYC)
) (
  input  wire logic       CLK_SYS_I,
  input  wire logic       RESET_I,
  input  wire logic       MAIN_ENABLE_I,
  input  wire logic       AUX_WAKE_INPUT_I,
  input  wire logic       REGULATORS_SETTLED_I,
  input  wire logic       OSC_STABLE_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WE_I,
  input  wire logic       REG_RE_I,
  output logic      [7:0] REG_RDATA_O,
  output logic      [7:0] REG_SETTING_O,
  output logic            TX_EN_O,
  output logic            RX_EN_O,
  output logic            HOST_CLOCK_HF_O,
  output logic            HOST_CLOCK_AUX_O,
  output logic            MCU_SUPPLY_EN_O,
  output logic            REGULATORS_EN_O,
  output logic            HALF_POWER_O,
  output logic            SUPPLY_5V_O,
  output logic            RF_READY_O,
  output logic      [2:0] POWER_STATE_O
);
  localparam logic [TIMER_W-1:0] MODE1_REC_CYCLES = TIMER_W'(MODE1_REC_CYC);

  pwr_state_t         state_ff;
  pwr_state_t         nxt_state;
  pwr_out_t           out_ff;
  pwr_out_t           nxt_out;
  logic [7:0]         chip_state_ff;
  logic [7:0]         nxt_chip_state;
  logic [7:0]         reg_setting_ff;
  logic [7:0]         rdata_ff;
  logic               aux_prev_ff;
  logic               wake_by_aux_ff;
  logic               rf_idle_ff;
  logic               rf_ready_ff;
  logic               aux_rise;
  logic               startup_done;
  logic               conf_load;
  logic               conf_done;
  logic               rec_load;
  logic               rec_done;
  logic               nxt_rf_idle;
  logic [TIMER_W-1:0] rec_val;

  assign aux_rise     = AUX_WAKE_INPUT_I && !aux_prev_ff;
  assign startup_done = REGULATORS_SETTLED_I && OSC_STABLE_I;
  assign conf_load    = (state_ff == ST_STARTUP) && (nxt_state == ST_CONFIRM);

  // register port
  assign nxt_chip_state = (REG_WE_I && REG_ADDR_I == ADDR_CHIP_STATE) ? REG_WDATA_I : chip_state_ff;

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      chip_state_ff  <= CHIP_STATE_RESET;
      reg_setting_ff <= REG_SETTING_RESET;
    end else begin
      chip_state_ff <= nxt_chip_state;
      if (REG_WE_I && REG_ADDR_I == ADDR_REG_SETTING) begin
        reg_setting_ff <= REG_WDATA_I;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_ff <= READ_UNMAPPED;
    end else if (REG_RE_I) begin
      unique case (REG_ADDR_I)
        ADDR_CHIP_STATE:  rdata_ff <= chip_state_ff;
        ADDR_REG_SETTING: rdata_ff <= reg_setting_ff;
        default:          rdata_ff <= READ_UNMAPPED;
      endcase
    end
  end

  // power state sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_OFF: begin
        if (MAIN_ENABLE_I || aux_rise) begin
          nxt_state = ST_STARTUP; // see [R3]
        end
      end
      ST_SLEEP: begin
        if (MAIN_ENABLE_I) begin
          nxt_state = ST_STARTUP;
        end else if (!AUX_WAKE_INPUT_I) begin
          nxt_state = ST_OFF; // see [R1]
        end
      end
      ST_STARTUP: begin
        if (!MAIN_ENABLE_I && !wake_by_aux_ff) begin
          nxt_state = AUX_WAKE_INPUT_I ? ST_SLEEP : ST_OFF;
        end else if (startup_done) begin
          nxt_state = MAIN_ENABLE_I ? ST_ACTIVE : ST_CONFIRM; // see [R4]
        end
      end
      ST_CONFIRM: begin
        if (MAIN_ENABLE_I) begin
          nxt_state = ST_ACTIVE; // see [R6]
        end else if (conf_done) begin
          nxt_state = ST_OFF; // see [R5]
        end
      end
      ST_ACTIVE: begin
        if (!MAIN_ENABLE_I) begin
          nxt_state = AUX_WAKE_INPUT_I ? ST_SLEEP : ST_OFF; // see [R2]
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_ff    <= ST_OFF;
      aux_prev_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      aux_prev_ff <= AUX_WAKE_INPUT_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      wake_by_aux_ff <= 1'b0;
    end else if (state_ff == ST_OFF && !MAIN_ENABLE_I && aux_rise) begin
      wake_by_aux_ff <= 1'b1;
    end else if (nxt_state != ST_STARTUP && nxt_state != ST_CONFIRM) begin
      wake_by_aux_ff <= 1'b0;
    end
  end

  power_wait_timer u_confirm_timer (
    .clk_i      (CLK_SYS_I),
    .rst_i      (RESET_I),
    .load_i     (conf_load),
    .load_val_i (CONFIRM_CYCLES),
    .done_o     (conf_done)
  );

  // output decode from the next state and next register value
  always_comb begin
    nxt_out = PWR_OUT_OFF; // see [R1]
    unique case (nxt_state)
      ST_OFF: begin
        nxt_out = PWR_OUT_OFF;
      end
      ST_SLEEP: begin
        nxt_out.aux_clk    = 1'b1; // see [R2]
        nxt_out.mcu_supply = 1'b1;
        nxt_out.regulators = 1'b1;
      end
      ST_STARTUP: begin
        nxt_out.aux_clk    = 1'b1;
        nxt_out.mcu_supply = 1'b1;
        nxt_out.regulators = 1'b1; // see [R3]
      end
      ST_CONFIRM: begin
        nxt_out.hf_clk     = 1'b1; // see [R4]
        nxt_out.mcu_supply = 1'b1;
        nxt_out.regulators = 1'b1;
      end
      ST_ACTIVE: begin
        nxt_out.hf_clk     = 1'b1;
        nxt_out.mcu_supply = 1'b1;
        nxt_out.regulators = 1'b1;
        nxt_out.supply_5v  = nxt_chip_state[BIT_SUPPLY_5V]; // see [R15]
        if (!nxt_chip_state[BIT_STANDBY]) begin // see [R10] [R11]
          if (nxt_chip_state[BIT_TX_RX]) begin
            nxt_out.tx_en      = 1'b1; // see [R14]
            nxt_out.rx_en      = 1'b1;
            nxt_out.half_power = nxt_chip_state[BIT_HALF_POWER]; // see [R15]
          end else if (nxt_chip_state[BIT_RX_ONLY]) begin
            nxt_out.rx_en = 1'b1; // see [R13]
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      out_ff <= PWR_OUT_OFF;
    end else begin
      out_ff <= nxt_out;
    end
  end

  // recovery from standby or mode 1 before the rf section counts as ready
  assign nxt_rf_idle = !(nxt_out.tx_en || nxt_out.rx_en);
  assign rec_load    = rf_idle_ff && !nxt_rf_idle;
  assign rec_val     = chip_state_ff[BIT_STANDBY] ? STANDBY_REC_CYCLES : MODE1_REC_CYCLES; // see [R11] [R12]

  power_wait_timer u_recover_timer (
    .clk_i      (CLK_SYS_I),
    .rst_i      (RESET_I),
    .load_i     (rec_load),
    .load_val_i (rec_val),
    .done_o     (rec_done)
  );

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      rf_idle_ff  <= 1'b1;
      rf_ready_ff <= 1'b0;
    end else begin
      rf_idle_ff  <= nxt_rf_idle;
      rf_ready_ff <= !nxt_rf_idle && !rec_load && rec_done;
    end
  end

  assign REG_RDATA_O      = rdata_ff;
  assign REG_SETTING_O    = reg_setting_ff;
  assign TX_EN_O          = out_ff.tx_en;
  assign RX_EN_O          = out_ff.rx_en;
  assign HOST_CLOCK_HF_O  = out_ff.hf_clk;
  assign HOST_CLOCK_AUX_O = out_ff.aux_clk;
  assign MCU_SUPPLY_EN_O  = out_ff.mcu_supply;
  assign REGULATORS_EN_O  = out_ff.regulators;
  assign HALF_POWER_O     = out_ff.half_power;
  assign SUPPLY_5V_O      = out_ff.supply_5v;
  assign RF_READY_O       = rf_ready_ff;
  assign POWER_STATE_O    = state_ff;

  a_off_all_quiet: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // see [R1]
    state_ff == ST_OFF |-> !TX_EN_O && !RX_EN_O && !HOST_CLOCK_HF_O && !HOST_CLOCK_AUX_O && !MCU_SUPPLY_EN_O)
    else $error("power down left something on");

  a_sleep_rail_clock: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // see [R2]
    state_ff == ST_SLEEP |-> MCU_SUPPLY_EN_O && HOST_CLOCK_AUX_O && !HOST_CLOCK_HF_O && !TX_EN_O && !RX_EN_O)
    else $error("sleep outputs wrong");

  a_aux_wake_start: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // see [R3]
    state_ff == ST_OFF && AUX_WAKE_INPUT_I && !aux_prev_ff |=> state_ff == ST_STARTUP && REGULATORS_EN_O)
    else $error("aux wake edge did not start supplies");

  a_hf_clock_switch: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // see [R4]
    state_ff == ST_STARTUP && startup_done && wake_by_aux_ff |=> HOST_CLOCK_HF_O && !HOST_CLOCK_AUX_O)
    else $error("clock did not switch after start-up");

  a_confirm_timeout: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // see [R5]
    state_ff == ST_CONFIRM && !MAIN_ENABLE_I && conf_done |=> state_ff == ST_OFF && !MCU_SUPPLY_EN_O)
    else $error("confirm window expiry did not power down");

  a_confirm_held: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // see [R6]
    state_ff == ST_CONFIRM && MAIN_ENABLE_I |=> state_ff == ST_ACTIVE && HOST_CLOCK_HF_O)
    else $error("main enable during window not honoured");

  a_standby_clock_on: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // see [R11]
    state_ff == ST_ACTIVE && chip_state_ff[BIT_STANDBY] |-> HOST_CLOCK_HF_O && !TX_EN_O && !RX_EN_O)
    else $error("standby outputs wrong");

  a_mode1_rf_off: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // see [R12]
    state_ff == ST_ACTIVE && !chip_state_ff[BIT_TX_RX] && !chip_state_ff[BIT_RX_ONLY] |-> !TX_EN_O && !RX_EN_O)
    else $error("mode 1 left rf on");

  a_rx_only_mode: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // see [R13]
    state_ff == ST_ACTIVE && !chip_state_ff[BIT_STANDBY] && !chip_state_ff[BIT_TX_RX] && chip_state_ff[BIT_RX_ONLY]
      |-> RX_EN_O && !TX_EN_O)
    else $error("receiver-only mode wrong");

  a_tx_rx_mode: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // see [R14] [R15]
    state_ff == ST_ACTIVE && !chip_state_ff[BIT_STANDBY] && chip_state_ff[BIT_TX_RX]
      |-> TX_EN_O && RX_EN_O && HALF_POWER_O == chip_state_ff[BIT_HALF_POWER])
    else $error("transmit and receive mode wrong");

  a_ready_after_wake: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // see [R12]
    rec_load |=> !RF_READY_O [*3])
    else $error("rf ready before recovery time");
endmodule

// ==== host_model.sv ====
// host pin driver and analog start-up model facing the power mode controller
`timescale 1ns/10ps
module host_model #(
  parameter int GAP    = 4,
  parameter int SETTLE = 6
) (
  input  wire logic clk_i,
  input  wire logic want_en_i,
  input  wire logic want_aux_i,
  input  wire logic reg_en_i,
  output logic      en_o,
  output logic      aux_o,
  output logic      settled_o
);
  int gap_cnt = 0;
  int set_cnt = 0;
  initial begin
    en_o = 1'b0;
    aux_o = 1'b0;
    settled_o = 1'b0;
  end
  // one pin moves at a time, so both never rise together
  always @(negedge clk_i) begin
    if (gap_cnt > 0)
      gap_cnt--;
    else if (want_en_i !== en_o) begin
      en_o = want_en_i;
      gap_cnt = GAP;
    end else if (want_aux_i !== aux_o) begin
      aux_o = want_aux_i;
      gap_cnt = GAP;
    end
    set_cnt = reg_en_i ? set_cnt + 1 : 0;
    settled_o = (set_cnt >= SETTLE);
  end
endmodule

// ==== testbench.sv ====
// self-checking bench for the reader power mode controller
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module testbench
  import rpm_pkg::*;
;
  localparam int CONF = 20;
  localparam int SB   = 20;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       want_en = 1'b0;
  logic       want_aux = 1'b0;
  logic       main_en, aux, settled;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       we = 1'b0;
  logic       re = 1'b0;
  logic [7:0] rdata, reg_set;
  logic       tx, rx, hf, auxc, mcu, regs, half, v5, rdy;
  logic [2:0] st;
  wire  [5:0] pw = {tx, rx, hf, auxc, mcu, regs};
  int         n_fail = 0;
  int         checks_done = 0;
  int         cycles = 0;

  always #5 clk = ~clk;

  host_model host (.clk_i(clk), .want_en_i(want_en), .want_aux_i(want_aux), .reg_en_i(regs),
    .en_o(main_en), .aux_o(aux), .settled_o(settled));

  reader_power_mode_control #(.CONFIRM_CYCLES(14'(CONF)), .STANDBY_REC_CYCLES(14'(SB))) dut (
    .CLK_SYS_I(clk), .RESET_I(rst), .MAIN_ENABLE_I(main_en), .AUX_WAKE_INPUT_I(aux),
    .REGULATORS_SETTLED_I(settled), .OSC_STABLE_I(settled), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rdata),
    .REG_SETTING_O(reg_set), .TX_EN_O(tx), .RX_EN_O(rx), .HOST_CLOCK_HF_O(hf),
    .HOST_CLOCK_AUX_O(auxc), .MCU_SUPPLY_EN_O(mcu), .REGULATORS_EN_O(regs),
    .HALF_POWER_O(half), .SUPPLY_5V_O(v5), .RF_READY_O(rdy), .POWER_STATE_O(st));

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    d = rdata;
  endtask

  task automatic wait_st(input logic [2:0] s, input int max);
    for (int i = 0; i < max && st !== s; i++) @(negedge clk);
  endtask

  task automatic t_reset;
    logic [7:0] d;
    `CHK("state", 3'h0, st)
    `CHK("outputs", 6'h00, pw)
    `CHK("regset", REG_SETTING_RESET, reg_set)
    rd(ADDR_REG_SETTING, d);
    `CHK("rd_0b", REG_SETTING_RESET, d)
    wr(ADDR_REG_SETTING, 8'h07);
    rd(ADDR_REG_SETTING, d);
    `CHK("rd_0b_new", 8'h07, d)
    wr(8'h05, 8'h5a);
    rd(8'h05, d);
    `CHK("unmapped", READ_UNMAPPED, d)
    $display("test reset done");
  endtask

  task automatic t_wake_timeout;
    want_aux = 1'b1;
    wait_st(3'h2, 20);
    `CHK("state_start", 3'h2, st)
    `CHK("pw_start", 6'b000111, pw)
    wait_st(3'h3, 40);
    `CHK("state_conf", 3'h3, st)
    `CHK("pw_conf", 6'b001011, pw)
    cyc(CONF - 3);
    `CHK("still_conf", 3'h3, st)
    // window opens at the switch edge, timer runs out after CONF cycles, off one edge later
    cyc(4);
    `CHK("state_off", 3'h0, st)
    `CHK("pw_off", 6'h00, pw)
    want_aux = 1'b0;
    cyc(8);
    $display("test wake timeout done");
  endtask

  task automatic t_confirm_modes;
    logic [7:0] cs [8] = '{8'h21, 8'h31, 8'h03, 8'h02, 8'h01, 8'h00, 8'h81, 8'h80};
    logic [7:0] d;
    logic       tx_x;
    logic [4:0] exp_m;
    want_aux = 1'b1;
    wait_st(3'h3, 40);
    want_en = 1'b1;
    wait_st(3'h4, 10);
    `CHK("state_act", 3'h4, st)
    cyc(CONF + 5);
    `CHK("stays_act", 3'h4, st)
    foreach (cs[i]) begin
      wr(ADDR_CHIP_STATE, cs[i]);
      tx_x = ~cs[i][7] & cs[i][5];
      exp_m = {tx_x, ~cs[i][7] & (cs[i][5] | cs[i][1]), tx_x & cs[i][4], cs[i][0], 1'b1};
      `CHK("modes", exp_m, {tx, rx, half, v5, hf})
      rd(ADDR_CHIP_STATE, d);
      `CHK("rd_00", cs[i], d)
    end
    $display("test confirm and modes done");
  endtask

  task automatic t_recovery;
    wr(ADDR_CHIP_STATE, 8'h20);
    cyc(SB - 3);
    `CHK("rdy_sb_early", 1'b0, rdy)
    for (int i = 0; i < 8 && rdy !== 1'b1; i++) @(negedge clk);
    `CHK("rdy_sb", 1'b1, rdy)
    wr(ADDR_CHIP_STATE, 8'h00);
    cyc(2);
    wr(ADDR_CHIP_STATE, 8'h20);
    cyc(MODE1_REC_CYC - 3);
    `CHK("rdy_m1_early", 1'b0, rdy)
    for (int i = 0; i < 8 && rdy !== 1'b1; i++) @(negedge clk);
    `CHK("rdy_m1", 1'b1, rdy)
    $display("test recovery done");
  endtask

  task automatic t_sleep;
    want_en = 1'b0;
    wait_st(3'h1, 20);
    `CHK("state_sleep", 3'h1, st)
    `CHK("pw_sleep", 6'b000111, pw)
    want_aux = 1'b0;
    wait_st(3'h0, 20);
    `CHK("state_down", 3'h0, st)
    `CHK("pw_down", 6'h00, pw)
    $display("test sleep done");
  endtask

  // host drives only the main enable, aux wake stays tied low; chip state still 0x20
  task automatic t_main_only;
    want_aux = 1'b0;
    want_en = 1'b1;
    wait_st(3'h2, 20);
    `CHK("state_mstart", 3'h2, st)
    `CHK("pw_mstart", 6'b000111, pw)
    wait_st(3'h4, 20);
    `CHK("state_mact", 3'h4, st)
    `CHK("pw_mact", 6'b111011, pw)
    `CHK("rdy_mact", 1'b0, rdy)
    want_en = 1'b0;
    wait_st(3'h0, 20);
    `CHK("state_moff", 3'h0, st)
    `CHK("pw_moff", 6'h00, pw)
    $display("test main enable only done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 10000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    cyc(2);
    rst = 1'b0;
    cyc(1);
    t_reset();
    t_wake_timeout();
    t_confirm_modes();
    t_recovery();
    t_sleep();
    t_main_only();
    report_and_stop();
  end
endmodule
